// ---- hdl/cma_pkg.sv ----
package cma_pkg;

  // Indexed register offsets
  localparam logic [7:0] OFS_CYCLE_COUNT = 8'h88;
  localparam logic [7:0] OFS_CONTROL     = 8'h89;
  localparam logic [7:0] OFS_PTR_HIGH    = 8'h8b;
  localparam logic [7:0] OFS_PTR_LOW     = 8'h8c;
  localparam logic [7:0] OFS_NV_PORT     = 8'h8d;
  localparam logic [7:0] OFS_SHADOW_PORT = 8'h8e;
  localparam logic [7:0] OFS_ROM_PORT    = 8'h8f;
  localparam logic [7:0] OFS_KEY         = 8'h90;
  localparam logic [7:0] OFS_PAGE_SELECT = 8'h91;

  // Control register bit positions
  localparam int CTRL_PROG_BIT = 0;
  localparam int CTRL_BUSY_BIT = 2;
  localparam int CTRL_FAIL_BIT = 5;
  localparam int CTRL_SNAP_BIT = 6;

  // Reset values and key
  localparam logic [7:0]  KEY_UNLOCK      = 8'hea;
  localparam logic [7:0]  KEY_RESET       = 8'h00;
  localparam logic [7:0]  COUNT_RESET     = 8'h00;
  localparam logic [7:0]  PTR_RESET       = 8'h00;
  localparam logic [3:0]  PAGE_SEL_RESET  = 4'h0;
  localparam logic [7:0]  READ_ZERO       = 8'h00;

  // Memory geometry
  localparam int NUM_PAGES     = 6;
  localparam int BASE_BYTES    = 64;
  localparam int PAGE_BYTES    = 64;
  localparam int PAGE_AW       = 6;
  localparam int SHADOW_DEPTH  = 512;
  localparam int SHADOW_AW     = 9;
  localparam int ROM_AW        = 12;
  localparam int DATA_W        = 8;

  // Three-level page pin coding
  localparam logic [1:0] LEVEL_LOW = 2'h0;
  localparam logic [1:0] LEVEL_MID = 2'h1;

  typedef struct packed {
    logic             rd;
    logic             wr;
    logic [7:0]       addr;
    logic [DATA_W-1:0] wdata;
  } cma_req_s;

  typedef struct packed {
    logic               valid;
    logic [PAGE_AW-1:0] addr;
    logic [DATA_W-1:0]  data;
  } cma_cfg_s;

  typedef enum logic [6:0] {
    ST_BOOT    = 7'h01,
    ST_LOAD_RD = 7'h02,
    ST_LOAD_WR = 7'h04,
    ST_IDLE    = 7'h08,
    ST_SNAP    = 7'h10,
    ST_PROG_RD = 7'h20,
    ST_PROG_WR = 7'h40
  } cma_state_e;

endpackage

// ---- hdl/cma_mem.sv ----
`timescale 1ns/1ps
module cma_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 512,
  parameter int AW    = 9
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [AW-1:0]    addr,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] array_reg [DEPTH];

  // Array itself is not reset; only the read register is
  always_ff @(posedge clock) begin
    if (wr_en) begin
      array_reg[addr] <= wdata;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata <= '0;
    end else begin
      rdata <= array_reg[addr];
    end
  end

endmodule

// ---- hdl/cma_top.sv ----
// Functional notes
// RL1 - Six pages, pin selected, loaded at reset
// RL2 - Host fills shadow page before programming
// RL3 - Busy bit set, nonvolatile access blocked
// RL4 - Host writes unlock key before programming
// RL5 - Program bit copies whole shadow to nonvolatile
// RL6 - Count successful programming cycles by one
// RL7 - Host relocks key after programming
// RL8 - Failure flag holds until successful reprogram
// RL9 - Nine-bit pointer from high and low
// RL10 - Shadow port reads, auto-increments within transaction
// RL11 - Nonvolatile port reads, auto-increments within transaction
// RL12 - Twelve-bit ROM pointer from high and low
// RL13 - ROM port reads, auto-increments within transaction
// RL14 - Host avoids back-to-back low pointer accesses
// RL15 - Snapshot bit copies live registers to page
// RL16 - Shadow port writes, auto-increments within transaction
// RL17 - Trigger ignored unless key unlocked
// RL18 - Command bits self-clear, busy clears at end
`timescale 1ns/1ps
module cma_top (
  input  wire logic                    clock,
  input  wire logic                    reset,
  input  wire cma_pkg::cma_req_s       req,
  input  wire logic                    txn_end,
  output logic [7:0]                   rd_data,
  output logic                         rd_valid,
  input  wire logic [1:0]              page_pin_high,
  input  wire logic [1:0]              page_pin_low,
  output logic [cma_pkg::PAGE_AW-1:0]  live_addr,
  input  wire logic [7:0]              live_data,
  output cma_pkg::cma_cfg_s            cfg,
  output logic                         load_done,
  output logic [cma_pkg::ROM_AW-1:0]   rom_addr,
  input  wire logic [7:0]              rom_data,
  input  wire logic                    nv_fail,
  output logic                         nv_busy,
  output logic                         locked
);
  import cma_pkg::*;

  typedef struct packed {
    cma_state_e      state;
    logic [7:0]      count;
    logic            busy;
    logic            fail;
    logic            prog_err;
    logic [7:0]      key;
    logic [7:0]      ptr_high;
    logic [7:0]      ptr_low;
    logic [ROM_AW-1:0] ptr;
    logic            open;
    logic [3:0]      page_sel;
    logic [2:0]      boot_page;
    logic [SHADOW_AW-1:0] cnt;
    logic            rd_pend;
    logic            rd_shadow;
    logic            rd_nv;
    logic [7:0]      hold;
    logic [7:0]      rdata;
    logic            rvalid;
    cma_cfg_s        cfg;
    logic            load_done;
  } cma_ctrl_s;

  localparam cma_ctrl_s CTRL_RESET = '{
    state:    ST_BOOT,
    count:    COUNT_RESET,
    key:      KEY_RESET,
    ptr_high: PTR_RESET,
    ptr_low:  PTR_RESET,
    page_sel: PAGE_SEL_RESET,
    default:  '0
  };

  localparam logic [SHADOW_AW-1:0] PAGE_LAST   = SHADOW_AW'(PAGE_BYTES - 1);
  localparam logic [SHADOW_AW-1:0] SHADOW_LAST = SHADOW_AW'(SHADOW_DEPTH - 1);

  cma_ctrl_s              r_reg;
  cma_ctrl_s              r_next;
  logic [SHADOW_AW-1:0]   sh_addr;
  logic                   sh_we;
  logic [7:0]             sh_wdata;
  logic [7:0]             sh_rdata;
  logic [SHADOW_AW-1:0]   nv_addr;
  logic                   nv_we;
  logic [7:0]             nv_wdata;
  logic [7:0]             nv_rdata;
  logic                   idle;
  logic                   access_ok;

  function automatic int level_of(input logic [1:0] pin);
    if (pin == LEVEL_LOW) begin
      return 0;
    end else if (pin == LEVEL_MID) begin
      return 1;
    end
    return 2;
  endfunction

  // Nine pin combinations fold onto six pages; the upper ones clamp to the last
  function automatic logic [2:0] page_of(input logic [1:0] high, input logic [1:0] low);
    int v;
    v = level_of(high) * 3 + level_of(low);
    if (v > NUM_PAGES - 1) begin
      v = NUM_PAGES - 1;
    end
    return 3'(v);
  endfunction

  function automatic logic [SHADOW_AW-1:0] page_base(input logic [2:0] page);
    return SHADOW_AW'(BASE_BYTES + int'(page) * PAGE_BYTES);
  endfunction

  cma_mem #(
    .WIDTH (8),
    .DEPTH (SHADOW_DEPTH),
    .AW    (SHADOW_AW)
  ) u_shadow (
    .clock (clock),
    .reset (reset),
    .addr  (sh_addr),
    .wr_en (sh_we),
    .wdata (sh_wdata),
    .rdata (sh_rdata)
  );

  cma_mem #(
    .WIDTH (8),
    .DEPTH (SHADOW_DEPTH),
    .AW    (SHADOW_AW)
  ) u_nonvolatile (
    .clock (clock),
    .reset (reset),
    .addr  (nv_addr),
    .wr_en (nv_we),
    .wdata (nv_wdata),
    .rdata (nv_rdata)
  );

  assign idle      = (r_reg.state == ST_IDLE);
  assign access_ok = idle && r_reg.open;

  always_comb begin
    r_next          = r_reg;
    r_next.rvalid   = 1'b0;
    r_next.rd_pend  = 1'b0;
    r_next.cfg.valid = 1'b0;
    sh_addr         = r_reg.ptr[SHADOW_AW-1:0];
    sh_we           = 1'b0;
    sh_wdata        = req.wdata;
    nv_addr         = r_reg.ptr[SHADOW_AW-1:0];
    nv_we           = 1'b0;
    nv_wdata        = sh_rdata;
    live_addr       = r_reg.cnt[PAGE_AW-1:0];

    // Second read cycle: memory data arrive from the read registers
    if (r_reg.rd_pend) begin
      r_next.rvalid = 1'b1;
      if (r_reg.rd_shadow) begin
        r_next.rdata = sh_rdata;
      end else if (r_reg.rd_nv) begin
        r_next.rdata = nv_rdata;
      end else begin
        r_next.rdata = r_reg.hold;
      end
    end

    // Port window closes with the bus transaction
    if (txn_end) begin
      r_next.open = 1'b0; // RL10 RL11 RL13 RL16
    end

    if (req.wr) begin
      unique case (req.addr)
        OFS_CONTROL: begin
          if (idle) begin
            if (req.wdata[CTRL_PROG_BIT] && r_reg.key == KEY_UNLOCK) begin // RL17
              r_next.state    = ST_PROG_RD; // RL5
              r_next.busy     = 1'b1; // RL3
              r_next.prog_err = 1'b0;
              r_next.cnt      = '0;
            end else if (req.wdata[CTRL_SNAP_BIT] && r_reg.page_sel < 4'(NUM_PAGES)) begin
              r_next.state = ST_SNAP; // RL15
              r_next.cnt   = '0;
            end
          end
        end
        OFS_PTR_HIGH: begin
          r_next.ptr_high = req.wdata;
        end
        OFS_PTR_LOW: begin
          r_next.ptr_low = req.wdata;
          r_next.ptr     = {r_reg.ptr_high[3:0], req.wdata}; // RL9 RL12
          r_next.open    = 1'b1;
        end
        OFS_SHADOW_PORT: begin
          if (access_ok) begin
            sh_we      = 1'b1; // RL16
            r_next.ptr = r_reg.ptr + 12'h001;
          end
        end
        OFS_KEY: begin
          r_next.key = req.wdata;
        end
        OFS_PAGE_SELECT: begin
          r_next.page_sel = req.wdata[3:0];
        end
        default: begin
        end
      endcase
    end

    if (req.rd) begin
      r_next.rd_pend   = 1'b1;
      r_next.rd_shadow = 1'b0;
      r_next.rd_nv     = 1'b0;
      r_next.hold      = READ_ZERO;
      unique case (req.addr)
        OFS_CYCLE_COUNT: begin
          r_next.hold = r_reg.count;
        end
        OFS_CONTROL: begin
          r_next.hold[CTRL_BUSY_BIT] = r_reg.busy; // RL3
          r_next.hold[CTRL_FAIL_BIT] = r_reg.fail; // RL8
        end
        OFS_PTR_HIGH: begin
          r_next.hold = r_reg.ptr_high;
        end
        OFS_PTR_LOW: begin
          r_next.hold = r_reg.ptr_low;
        end
        OFS_NV_PORT: begin
          if (access_ok) begin
            r_next.rd_nv = 1'b1; // RL11 RL3
            r_next.ptr   = r_reg.ptr + 12'h001;
          end
        end
        OFS_SHADOW_PORT: begin
          if (access_ok) begin
            r_next.rd_shadow = 1'b1; // RL10
            r_next.ptr       = r_reg.ptr + 12'h001;
          end
        end
        OFS_ROM_PORT: begin
          if (access_ok) begin
            r_next.hold = rom_data; // RL13
            r_next.ptr  = r_reg.ptr + 12'h001;
          end
        end
        OFS_KEY: begin
          r_next.hold = r_reg.key;
        end
        OFS_PAGE_SELECT: begin
          r_next.hold = {4'h0, r_reg.page_sel};
        end
        default: begin
        end
      endcase
    end

    unique case (r_reg.state)
      ST_BOOT: begin
        r_next.boot_page = page_of(page_pin_high, page_pin_low); // RL1
        r_next.cnt       = '0;
        r_next.state     = ST_LOAD_RD;
      end
      ST_LOAD_RD: begin
        nv_addr      = page_base(r_reg.boot_page) + r_reg.cnt; // RL1
        r_next.state = ST_LOAD_WR;
      end
      ST_LOAD_WR: begin
        r_next.cfg.valid = 1'b1;
        r_next.cfg.addr  = r_reg.cnt[PAGE_AW-1:0];
        r_next.cfg.data  = nv_rdata;
        r_next.cnt       = r_reg.cnt + 9'h001;
        if (r_reg.cnt == PAGE_LAST) begin
          r_next.state     = ST_IDLE;
          r_next.load_done = 1'b1;
        end else begin
          r_next.state = ST_LOAD_RD;
        end
      end
      ST_IDLE: begin
      end
      ST_SNAP: begin
        sh_addr    = page_base(r_reg.page_sel[2:0]) + r_reg.cnt; // RL15
        sh_we      = 1'b1;
        sh_wdata   = live_data;
        r_next.cnt = r_reg.cnt + 9'h001;
        if (r_reg.cnt == PAGE_LAST) begin
          r_next.state = ST_IDLE; // RL18
        end
      end
      ST_PROG_RD: begin
        sh_addr      = r_reg.cnt; // RL5
        r_next.state = ST_PROG_WR;
      end
      ST_PROG_WR: begin
        nv_we           = 1'b1; // RL5
        nv_addr         = r_reg.cnt;
        r_next.prog_err = r_reg.prog_err | nv_fail;
        r_next.cnt      = r_reg.cnt + 9'h001;
        r_next.state    = ST_PROG_RD;
        if (r_reg.cnt == SHADOW_LAST) begin
          r_next.state = ST_IDLE;
          r_next.busy  = 1'b0; // RL18
          if (r_reg.prog_err | nv_fail) begin
            r_next.fail = 1'b1; // RL8
          end else begin
            r_next.fail  = 1'b0; // RL8
            r_next.count = r_reg.count + 8'h01; // RL6
          end
        end
      end
      default: begin
        r_next.state = ST_IDLE;
        r_next.busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      r_reg <= CTRL_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rd_data   = r_reg.rdata;
  assign rd_valid  = r_reg.rvalid;
  assign cfg       = r_reg.cfg;
  assign load_done = r_reg.load_done;
  assign rom_addr  = r_reg.ptr;
  assign nv_busy   = r_reg.busy;
  assign locked    = r_reg.fail;

endmodule

// ---- tb/cma_properties.sv ----
`timescale 1ns/1ps
module cma_properties (
  input wire logic              clock,
  input wire logic              reset,
  input wire cma_pkg::cma_req_s req,
  input wire logic [7:0]        rd_data,
  input wire logic              rd_valid,
  input wire cma_pkg::cma_cfg_s cfg,
  input wire logic              load_done,
  input wire logic              nv_busy,
  input wire logic              locked
);
  import cma_pkg::*;
  logic [10:0] busy_cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Length of the busy phase, 512 bytes at two cycles each
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      busy_cnt <= 11'h0;
    end else begin
      busy_cnt <= nv_busy ? busy_cnt + 11'h1 : 11'h0;
    end
  end
  property p_rd_lat; req.rd |-> ##2 rd_valid; endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer not two cycles after strobe");
  property p_rd_src; rd_valid |-> $past(req.rd, 2); endproperty
  a_rd_src: assert property (p_rd_src)
    else $error("read answer without a read");
  property p_busy_cause;
    $rose(nv_busy) |-> $past(req.wr && req.addr == OFS_CONTROL && req.wdata[CTRL_PROG_BIT]);
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy without program trigger");
  property p_busy_min; $rose(nv_busy) |=> nv_busy [*8]; endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("busy dropped early");
  property p_busy_len; $fell(nv_busy) |-> busy_cnt == 11'd1024; endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy length wrong");
  property p_lock_src; $changed(locked) |-> $past(nv_busy) || $past(nv_busy, 2); endproperty
  a_lock_src: assert property (p_lock_src)
    else $error("fail flag changed outside programming");
  property p_load_hold; load_done |=> load_done; endproperty
  a_load_hold: assert property (p_load_hold)
    else $error("load done dropped");
  property p_cfg_boot; load_done |=> !cfg.valid; endproperty
  a_cfg_boot: assert property (p_cfg_boot)
    else $error("boot write after load done");
  property p_nv_block;
    req.rd && req.addr == OFS_NV_PORT && nv_busy |-> ##2 rd_data == READ_ZERO;
  endproperty
  a_nv_block: assert property (p_nv_block)
    else $error("nonvolatile read while busy");
  property p_ctrl_clr; req.rd && req.addr == OFS_CONTROL |-> ##2 !rd_data[0] && !rd_data[6]; endproperty
  a_ctrl_clr: assert property (p_ctrl_clr)
    else $error("command bits read back set");
endmodule
bind cma_top cma_properties u_props (.clock, .reset, .req, .rd_data, .rd_valid, .cfg, .load_done, .nv_busy, .locked);

// ---- tb/cma_env_model.sv ----
`timescale 1ns/1ps
module cma_env_model (
  input wire logic [11:0] rom_addr,
  output logic     [7:0]  rom_data,
  input wire logic [5:0]  live_addr,
  output logic     [7:0]  live_data
);
  // ROM and live registers answer at once, as pattern of their index
  assign rom_data  = rom_addr[7:0] ^ {rom_addr[11:8], rom_addr[11:8]};
  assign live_data = {2'b10, live_addr};
endmodule

// ---- tb/config_memory_access_tb.sv ----
`timescale 1ns/1ps
module config_memory_access_tb;
  import cma_pkg::*;
  logic clock, reset, txn_end, rd_valid, load_done, nv_fail, nv_busy, locked;
  logic [1:0]  pin_hi, pin_lo;
  logic [5:0]  live_addr;
  logic [7:0]  rd_data, live_data, rom_data, sh [512];
  logic [11:0] rom_addr;
  logic [15:0] lfsr;
  logic [8:0]  a9;
  cma_req_s    req;
  cma_cfg_s    cfg;
  int          failures, checks_done, cfg_n, page, i;
  cma_top uut (.clock, .reset, .req, .txn_end, .rd_data, .rd_valid, .page_pin_high(pin_hi),
    .page_pin_low(pin_lo), .live_addr, .live_data, .cfg, .load_done, .rom_addr, .rom_data,
    .nv_fail, .nv_busy, .locked);
  cma_env_model env (.rom_addr, .rom_data, .live_addr, .live_data);
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] rom_exp(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction
  task automatic tally_and_finish;
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    req = {2'b01, a, d};
    @(negedge clock);
    req = '0;
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
    int n;
    // Keeps read strobes at least three cycles apart
    repeat (2) @(negedge clock);
    req = {2'b10, a, 8'h00};
    @(negedge clock);
    req = '0;
    for (n = 0; n < 4 && rd_valid !== 1'b1; n++) @(posedge clock) #1;
    if (rd_valid !== 1'b1) begin
      failures++;
      tally_and_finish;
    end
    chk(what, {4'h0, rd_data}, {4'h0, exp});
  endtask
  task automatic tend;
    @(negedge clock);
    txn_end = 1'b1;
    @(negedge clock);
    txn_end = 1'b0;
  endtask
  task automatic boot(input logic [1:0] h, input logic [1:0] l, input int pg);
    int n;
    reset = 1'b1;
    pin_hi = h;
    pin_lo = l;
    page = pg;
    repeat (16) @(negedge clock);
    cfg_n = 0;
    reset = 1'b0;
    for (n = 0; n < 300 && load_done !== 1'b1; n++) @(negedge clock);
    if (load_done !== 1'b1) begin
      failures++;
      tally_and_finish;
    end
    @(negedge clock);
    chk("boot writes", 12'(cfg_n), 12'd64);
  endtask
  task automatic prog(input logic [7:0] busy_ctrl, input logic [7:0] end_ctrl);
    int n;
    wr(OFS_KEY, KEY_UNLOCK);
    rdc("key", OFS_KEY, KEY_UNLOCK);
    wr(OFS_CONTROL, 8'h01);
    // Open the port window so only busy can block the read
    wr(OFS_PTR_LOW, 8'h00);
    rdc("busy control", OFS_CONTROL, busy_ctrl);
    rdc("nv while busy", OFS_NV_PORT, 8'h00);
    for (n = 0; n < 1100 && nv_busy !== 1'b0; n++) @(negedge clock);
    if (nv_busy !== 1'b0) begin
      failures++;
      tally_and_finish;
    end
    wr(OFS_KEY, KEY_RESET);
    rdc("end control", OFS_CONTROL, end_ctrl);
  endtask
  always @(negedge clock) begin
    if (cfg.valid === 1'b1) begin
      chk("boot addr", {6'h0, cfg.addr}, 12'(cfg_n));
      if (page >= 0) chk("boot data", {4'h0, cfg.data}, {4'h0, sh[64 + 64 * page + cfg.addr]});
      cfg_n++;
    end
  end
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    req = '0;
    txn_end = 1'b0;
    nv_fail = 1'b0;
    failures = 0;
    checks_done = 0;
    lfsr = 16'hbfd5;
    boot(2'h0, 2'h0, -1);
    rdc("count reset", OFS_CYCLE_COUNT, COUNT_RESET);
    rdc("unmapped", 8'h87, READ_ZERO);
    wr(OFS_PTR_HIGH, 8'h01);
    wr(OFS_PTR_LOW, 8'hfc);
    for (i = 0; i < 6; i++) begin
      lfsr = lfsr_step(lfsr);
      a9 = 9'h1fc + 9'(i);
      sh[a9] = lfsr[7:0];
      wr(OFS_SHADOW_PORT, lfsr[7:0]);
    end
    tend;
    rdc("closed window", OFS_SHADOW_PORT, READ_ZERO);
    wr(OFS_PTR_HIGH, 8'h01);
    wr(OFS_PTR_LOW, 8'hfc);
    for (i = 0; i < 6; i++) rdc("shadow", OFS_SHADOW_PORT, sh[9'h1fc + 9'(i)]);
    tend;
    wr(OFS_PTR_HIGH, 8'h0a);
    wr(OFS_PTR_LOW, 8'hfe);
    for (i = 0; i < 3; i++) rdc("rom", OFS_ROM_PORT, rom_exp(12'hafe + 12'(i)));
    tend;
    wr(OFS_PAGE_SELECT, 8'h02);
    wr(OFS_CONTROL, 8'h40);
    repeat (70) @(negedge clock);
    for (i = 0; i < 64; i++) sh[192 + i] = {2'b10, 6'(i)};
    wr(OFS_PTR_HIGH, 8'h00);
    wr(OFS_PTR_LOW, 8'hc0);
    for (i = 0; i < 4; i++) rdc("snapshot", OFS_SHADOW_PORT, sh[192 + i]);
    tend;
    // Locked key and an out-of-range page: neither command may start
    wr(OFS_PAGE_SELECT, 8'h07);
    wr(OFS_CONTROL, 8'h41);
    repeat (4) @(negedge clock);
    chk("locked trigger", {11'h0, nv_busy}, 12'h0);
    rdc("page select", OFS_PAGE_SELECT, 8'h07);
    rdc("count locked", OFS_CYCLE_COUNT, 8'h00);
    prog(8'h04, 8'h00);
    rdc("count one", OFS_CYCLE_COUNT, 8'h01);
    boot(LEVEL_LOW, 2'h2, 2);
    wr(OFS_PTR_HIGH, 8'h01);
    wr(OFS_PTR_LOW, 8'hfc);
    for (i = 0; i < 6; i++) rdc("nonvolatile", OFS_NV_PORT, sh[9'h1fc + 9'(i)]);
    tend;
    nv_fail = 1'b1;
    prog(8'h04, 8'h20);
    nv_fail = 1'b0;
    chk("locked", {11'h0, locked}, 12'h1);
    rdc("count after fail", OFS_CYCLE_COUNT, 8'h00);
    prog(8'h24, 8'h00);
    rdc("count recover", OFS_CYCLE_COUNT, 8'h01);
    tally_and_finish;
  end
endmodule
